// File: test/sbt_engine_props.sv
// Checker: port-level properties of the serial block transfer engine
module sbt_engine_props
	import sbt_pkg::*;
#(
	parameter int BAUD_DIV = 8,         // Clock cycles per serial bit
	parameter int DEPTH    = MAX_WORDS  // Words in each buffer
) (
	input wire logic        clk_i,                    // System clock
	input wire logic        rstn_i,                   // Synchronous reset, active low
	input wire logic [11:0] addr_i,                   // Register word address
	input wire logic [15:0] wdata_i,                  // Write data
	input wire logic        wr_i,                     // Write strobe
	input wire logic        rd_i,                     // Read strobe
	input wire logic [15:0] rdata_o,                  // Read data
	input wire logic        ser_rx_i,                 // Serial receive line
	input wire logic        ser_tx_o,                 // Serial transmit line
	input wire logic        driver_en_o,              // Line driver enable
	input wire logic [1:0]  port_interface_select_o,  // Applied interface select
	input wire logic        special_char_interrupt_o  // Special character pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	logic [15:0] run;      // Length of the current level run on the transmit line
	logic        prev_tx;  // Line level one cycle back
	wire  logic  tx_moved = (ser_tx_o != prev_tx);                 // Level changed
	wire  logic [15:0] next_run = tx_moved ? 16'h0001 : run + 16'h0001;
	wire  logic  buf_win = (addr_i[11:10] == WIN_TX_BUF) || (addr_i[11:10] == WIN_RX_BUF);

	// Run counter; reset to idle-high so a cut character never looks short
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			run     <= 16'h0000;
			prev_tx <= 1'b1;
		end else begin
			run     <= next_run;
			prev_tx <= ser_tx_o;
		end
	end

	a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data not zero without a read");
	a_unmapped_zero: assert property (rd_i && addr_i == 12'h0FF |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_window_zero: assert property (
		rd_i && buf_win && addr_i[9:0] >= DEPTH |=> rdata_o == 16'h0000)
		else $error("buffer read beyond depth not zero");
	a_rst_outputs: assert property (disable iff (1'b0)
		!rstn_i |=> rdata_o == 16'h0000 && ser_tx_o && !driver_en_o
		&& port_interface_select_o == IFACE_RS232 && !special_char_interrupt_o)
		else $error("outputs not at reset values");
	a_irq_pulse: assert property (special_char_interrupt_o |=> !special_char_interrupt_o)
		else $error("special interrupt longer than one cycle");
	a_drv_rs232: assert property (
		port_interface_select_o == IFACE_RS232 |-> !driver_en_o)
		else $error("driver enabled in RS-232 mode");
	a_low_run: assert property ($rose(ser_tx_o) |-> run % BAUD_DIV == 0)
		else $error("low run not a whole number of bit times");
	a_stop_width: assert property ($fell(ser_tx_o) |-> run >= BAUD_DIV)
		else $error("stop bit or idle shorter than one bit time");
endmodule : sbt_engine_props

// File: test/sbt_engine_tb.sv
// Testbench: register-level scenarios for the serial block transfer engine
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module sbt_engine_tb
	import sbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BD = 8;  // Short bit time keeps the run brief

	logic        clk_i = 1'b0;               // Clock, starts low
	logic        rstn_i, wr_i, rd_i;         // Reset and strobes
	logic [11:0] addr_i;                     // Address
	logic [15:0] wdata_i, rdata_o, v;        // Bus data and read result
	logic        ser_rx_i, ser_tx_o, driver_en_o, irq;  // Serial and side outputs
	logic [1:0]  sel;                        // Applied interface select
	int          bad_count, checks, irq_n, drv_n;  // Counters
	sbt_cfg_type cfg;                        // Configuration word
	logic [11:0] ra [7] = '{OFF_FORMAT, OFF_TIMEOUT, OFF_RESEND, OFF_STATUS,
		OFF_ERRCODE, 12'h0FF, 12'h9F4};
	logic [15:0] re [7] = '{FORMAT_RST, TIMEOUT_RST, RESEND_RST, 16'h0000,
		16'h0000, 16'h0000, 16'h0000};

	sbt_engine #(.DEPTH(MAX_WORDS), .BAUD_DIV(BD), .MS_CYCLES(20)) u_sbt_engine (
		.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ser_rx_i(ser_rx_i),
		.ser_tx_o(ser_tx_o), .driver_en_o(driver_en_o),
		.port_interface_select_o(sel), .special_char_interrupt_o(irq));
	sbt_serial_peer #(.BAUD_DIV(BD), .NBITS(7)) u_sbt_serial_peer (
		.clk_i(clk_i), .line_i(ser_tx_o), .line_o(ser_rx_i));

	always #10 clk_i = ~clk_i;

	// Count special character pulses and line driver cycles
	always @(posedge clk_i) begin
		if (irq === 1'b1) irq_n++;
		if (driver_en_o === 1'b1) drv_n++;
	end

	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	// Poll one status bit under a bounded count
	task wait_bit(input int b, input logic val);
		for (int i = 0; i < 500; i++) begin
			rd(OFF_STATUS, v);
			if (v[b] === val) break;
		end
		`CHK("status flag", val, v[b])
	endtask : wait_bit

	task finish_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test

	initial begin : watchdog
		repeat (40000) @(posedge clk_i);
		bad_count++;
		finish_test;
	end

	initial begin : main
		{rstn_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		wr(OFF_ERRCODE, 16'h1234);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], v);
			`CHK("reset value", re[i], v)
		end
		// Settings take effect only with the protocol enabled
		cfg = '{iface: 2'h3, proto_en: 1'b0, byte_mode: 1'b0};
		wr(OFF_CONFIG, {12'h000, cfg});
		repeat (2) @(posedge clk_i);
		`CHK("select off", IFACE_RS232, sel)
		cfg.proto_en = 1'b1;
		wr(OFF_CONFIG, {12'h000, cfg});
		repeat (2) @(posedge clk_i);
		`CHK("select on", 2'h3, sel)
		cfg.iface = IFACE_RS232;
		wr(OFF_CONFIG, {12'h000, cfg});
		// Oversized count is skipped
		wr(OFF_TX_COUNT, 16'h01F5);
		wr(OFF_CTRL, 16'h0001);
		repeat (4) @(posedge clk_i);
		rd(OFF_STATUS, v);
		`CHK("op error", 16'h0008, v)
		rd(OFF_ERRCODE, v);
		`CHK("code", ERR_COUNT_RANGE, v)
		wr(OFF_STATUS, 16'h0008);
		// 16-bit packing, both directions
		wr(12'h400, 16'h2301);
		wr(OFF_TX_COUNT, 16'h0001);
		wr(OFF_RX_START, 16'h0003);
		wr(OFF_RX_COUNT, 16'h0001);
		wr(OFF_CTRL, 16'h0001);
		wait_bit(ST_RX_WAIT, 1'b1);
		wr(OFF_TX_COUNT, 16'h0005);
		u_sbt_serial_peer.send_byte(8'h45);
		u_sbt_serial_peer.send_byte(8'h67);
		wait_bit(ST_RX_DONE, 1'b1);
		rd(OFF_STATUS, v);
		`CHK("done", 16'h0001, v)
		rd(12'h803, v);
		`CHK("rx word", 16'h6745, v)
		`CHK("tx bytes", 16'h2301, {u_sbt_serial_peer.byte_q[1], u_sbt_serial_peer.byte_q[0]})
		rd(OFF_TX_COUNT, v);
		`CHK("busy write", 16'h0001, v)
		wr(OFF_STATUS, 16'h0001);
		rd(OFF_STATUS, v);
		`CHK("cleared", 16'h0000, v)
		// 8-bit packing with special character
		cfg.byte_mode = 1'b1;
		wr(OFF_CONFIG, {12'h000, cfg});
		wr(OFF_SPECIAL, 16'h0034);
		wr(12'h400, 16'hAA12);
		wr(OFF_RX_START, 16'h0000);
		wr(OFF_CTRL, 16'h0001);
		wait_bit(ST_RX_WAIT, 1'b1);
		u_sbt_serial_peer.send_byte(8'h34);
		wait_bit(ST_RX_DONE, 1'b1);
		rd(OFF_STATUS, v);
		`CHK("special", 16'h0011, v)
		rd(12'h800, v);
		`CHK("rx byte", 16'h0034, v)
		`CHK("tx byte", 8'h12, u_sbt_serial_peer.byte_q[2])
		`CHK("pulses", 1, irq_n)
		wr(OFF_STATUS, 16'h0011);
		// Send-only transfer on a driven interface
		cfg.iface = 2'h1;
		wr(OFF_CONFIG, {12'h000, cfg});
		wr(OFF_RX_COUNT, 16'h0000);
		wr(OFF_CTRL, 16'h0001);
		repeat (4) @(posedge clk_i);
		wait_bit(ST_BUSY, 1'b0);
		rd(OFF_STATUS, v);
		`CHK("send only", 16'h0000, v)
		`CHK("sent", 4, u_sbt_serial_peer.byte_q.size())
		`CHK("driver on", 9 * BD, drv_n)
		// No reply: one resend, then timeout error
		wr(OFF_RX_COUNT, 16'h0001);
		wr(OFF_RESEND, 16'h0001);
		wr(OFF_TIMEOUT, 16'h0002);
		wr(OFF_CTRL, 16'h0001);
		wait_bit(ST_RX_ERR, 1'b1);
		`CHK("resent", 6, u_sbt_serial_peer.byte_q.size())
		rd(OFF_STATUS, v);
		`CHK("timeout", 16'h0004, v)
		rd(OFF_ERRCODE, v);
		`CHK("code", ERR_RX_TIMEOUT, v)
		wr(OFF_STATUS, 16'h0004);
		rd(OFF_STATUS, v);
		`CHK("error cleared", 16'h0000, v)
		finish_test;
	end
endmodule : sbt_engine_tb

bind sbt_engine sbt_engine_props #(.BAUD_DIV(BAUD_DIV), .DEPTH(DEPTH)) u_sbt_engine_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o),
	.driver_en_o(driver_en_o), .port_interface_select_o(port_interface_select_o),
	.special_char_interrupt_o(special_char_interrupt_o));

// File: test/sbt_serial_peer.sv
// Partner model: external serial device, 7N1 receiver and transmitter
module sbt_serial_peer #(
	parameter int BAUD_DIV = 8,  // Clock cycles per bit
	parameter int NBITS    = 7   // Data bits per character
) (
	input  wire logic clk_i,   // Clock used to time bits
	input  wire logic line_i,  // Line from the engine
	output logic      line_o   // Line to the engine, idle high
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] byte_q [$];  // Characters seen from the engine
	logic [7:0] cap;         // Character being assembled

	initial line_o = 1'b1;

	// Receiver: sample mid-bit, LSB first, unused top bits stay zero
	always begin : rx_proc
		@(negedge line_i);
		repeat (BAUD_DIV / 2) @(posedge clk_i);
		cap = 8'h00;
		for (int i = 0; i < NBITS; i++) begin
			repeat (BAUD_DIV) @(posedge clk_i);
			cap[i] = line_i;
		end
		repeat (BAUD_DIV) @(posedge clk_i);
		byte_q.push_back(cap);
	end

	// Transmitter: start bit, data LSB first, one stop bit
	task send_byte(input logic [7:0] b);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (BAUD_DIV) @(posedge clk_i);
		for (int i = 0; i < NBITS; i++) begin
			line_o <= b[i];
			repeat (BAUD_DIV) @(posedge clk_i);
		end
		line_o <= 1'b1;
		repeat (BAUD_DIV) @(posedge clk_i);
	endtask : send_byte
endmodule : sbt_serial_peer

// File: verilog/sbt_engine.sv
// Serial block transfer engine: buffers, register port, UART framing and transfer control
//
// The strobed register port and the register addresses were decided locally.

// What this block does
// (R1) Send tx_count words from tx_start, store rx_count
// (R2) Counts above 500 words are unsupported
// (R3) Zero counts allowed: send-only or receive-only
// (R4) One transfer at a time, others wait
// (R5) Operand and buffer writes ignored while busy
// (R6) 8-bit mode: low byte only per word
// (R7) 16-bit mode: earlier byte low, later high
// (R8) Byte-mode flag set selects 8-bit, clear 16-bit
// (R9) Interface select value 0 means RS-232
// (R10) Format code 0x0020 gives 9600 7N1
// (R11) Resend count bounds command retransmissions
// (R12) Timeout in milliseconds bounds reply wait
// (R13) Port settings applied only when protocol enabled
// (R14) Engine clears send request after sending completes
// (R15) Software never clears the send request
// (R16) Received words stored consecutively from rx_start
// (R17) Engine sets rx-done, software clears it
// (R18) Special character received raises special interrupt
// (R19) Rx-waiting flag held while awaiting reply
// (R20) Reception error sets flag and logs code
// (R21) Out-of-range count: skip, flag, code 0x200B
// (R22) Timeout resends while allowed, then reports error
module sbt_engine
	import sbt_pkg::*;
#(
	parameter int DEPTH     = MAX_WORDS,         // Words in each buffer
	parameter int BAUD_DIV  = CLK_HZ / BAUD_HZ,  // Clock cycles per serial bit
	parameter int MS_CYCLES = CLK_HZ / MS_PER_S  // Clock cycles per millisecond
) (
	input  wire logic        clk_i,                    // System clock
	input  wire logic        rstn_i,                   // Synchronous reset, active low
	input  wire logic [11:0] addr_i,                   // Register word address
	input  wire logic [15:0] wdata_i,                  // Write data
	input  wire logic        wr_i,                     // Write strobe
	input  wire logic        rd_i,                     // Read strobe
	output logic      [15:0] rdata_o,                  // Read data, cycle after strobe
	input  wire logic        ser_rx_i,                 // Serial receive line
	output logic             ser_tx_o,                 // Serial transmit line
	output logic             driver_en_o,              // Line driver enable for 422/485
	output logic      [1:0]  port_interface_select_o,  // Applied interface select
	output logic             special_char_interrupt_o  // One-cycle special character pulse
);

	localparam int IDX_W = $clog2(DEPTH);

	// Software registers
	sbt_cfg_type   cfg;            // Configuration as written
	logic [15:0]   port_format_code;
	logic [15:0]   port_resend_count;
	logic [15:0]   port_reply_timeout;
	logic [15:0]   special_char_value;
	logic [15:0]   error_code_word;
	logic [15:0]   tx_start, tx_count, rx_start, rx_count;
	logic          port1_send_request, port1_rx_done, port1_rx_waiting;
	logic          port1_rx_error, operation_error_flag, special_seen;
	// Settings in force, loaded only while the protocol is enabled
	sbt_cfg_type   act_cfg;
	logic [15:0]   act_format, act_resend, act_timeout;
	// Buffers
	logic [15:0]   tx_buf [DEPTH];
	logic [15:0]   rx_buf [DEPTH];
	// Engine state
	sbt_state_type state;
	logic [9:0]    tx_pos, rx_pos;   // Byte counters within the block
	logic [15:0]   retries;          // Resends still allowed
	logic [15:0]   ms_pre, ms_cnt;   // Reply timeout timer
	logic [7:0]    rx_low;           // Held low byte in 16-bit mode
	// Transmitter
	logic [15:0]   tx_baud;
	logic [9:0]    tx_sh;
	logic [3:0]    tx_left;
	// Receiver
	logic [15:0]   rx_baud;
	logic [3:0]    rx_bitn;
	logic [7:0]    rx_sh;
	logic          rx_run;

	// Data bits per character for a format code
	function automatic logic [3:0] fmt_bits(input logic [15:0] code);
		fmt_bits = (code == FMT_9600_7N1) ? BITS_7 : BITS_8; // [R10]
	endfunction : fmt_bits

	// True when a block does not fit the supported size or buffer
	function automatic logic range_bad(input logic [15:0] start, input logic [15:0] cnt);
		range_bad = (cnt > 16'(MAX_WORDS)) || ({1'b0, start} + {1'b0, cnt} > 17'(DEPTH));
	endfunction : range_bad

	// Register port decode
	wire        busy      = (state != S_IDLE);
	wire        reg_hit   = (addr_i[11:10] == 2'h0);
	wire        wr_reg    = wr_i && reg_hit;
	wire        wr_oper   = wr_reg && !busy;                                  // [R5]
	wire        wr_txbuf  = wr_i && !busy && (addr_i[11:10] == WIN_TX_BUF); // [R5]
	wire [9:0]  win_idx   = addr_i[9:0];
	wire        win_ok    = ({22'h0, win_idx} < 32'(DEPTH));
	wire        wr_ctrl   = wr_reg && (addr_i == OFF_CTRL);
	wire        wr_status = wr_reg && (addr_i == OFF_STATUS);
	wire [15:0] clr_bits  = wr_status ? wdata_i : 16'h0000;
	wire [15:0] status_w  = {9'h0, port1_send_request, busy, special_seen,
		operation_error_flag, port1_rx_error, port1_rx_waiting, port1_rx_done};

	// Packing mode and frame size in force
	wire        byte_mode = act_cfg.byte_mode;                // [R8]
	wire [3:0]  data_bits = fmt_bits(act_format);
	wire [9:0]  tx_total  = byte_mode ? tx_count[9:0] : {tx_count[8:0], 1'b0};
	wire [9:0]  rx_total  = byte_mode ? rx_count[9:0] : {rx_count[8:0], 1'b0};

	// Transmit byte fetch: word from tx_start onward, low byte first
	wire [9:0]  tx_word   = byte_mode ? tx_pos : {1'b0, tx_pos[9:1]};
	wire [9:0]  tx_addr   = tx_start[9:0] + tx_word;                          // [R1]
	wire [15:0] tx_wd     = tx_buf[IDX_W'(tx_addr)];
	wire        tx_hi     = !byte_mode && tx_pos[0];                          // [R7]
	wire [7:0]  tx_byte   = tx_hi ? tx_wd[15:8] : tx_wd[7:0];                 // [R6]
	wire [7:0]  tx_data   = (data_bits == BITS_7) ? {1'b0, tx_byte[6:0]} : tx_byte;
	wire        tx_idle   = (tx_left == 4'h0);
	wire        tx_load   = (state == S_SEND) && tx_idle && (tx_pos != tx_total);
	wire        send_end  = (state == S_SEND) && tx_idle && (tx_pos == tx_total);

	// Receiver events: a byte is complete at the stop bit sample
	wire        rx_stop   = rx_run && (rx_baud == 16'h0) && (rx_bitn == data_bits + 4'h1);
	wire        rx_byte_v = rx_stop && ser_rx_i;
	wire        rx_frame  = rx_stop && !ser_rx_i;
	wire [7:0]  rx_byte   = (data_bits == BITS_7) ? {1'b0, rx_sh[7:1]} : rx_sh;
	wire        rx_word_v = rx_byte_v && (byte_mode || rx_pos[0]);
	wire [15:0] rx_word   = byte_mode ? {8'h00, rx_byte} : {rx_byte, rx_low}; // [R6] [R7]
	wire [9:0]  rx_widx   = byte_mode ? rx_pos : {1'b0, rx_pos[9:1]};
	wire [9:0]  rx_addr   = rx_start[9:0] + rx_widx;                          // [R16]
	wire        rx_last   = rx_byte_v && (rx_pos + 10'h1 == rx_total);
	wire        rx_special = rx_byte_v && (rx_byte == special_char_value[7:0]); // [R18]

	// Reply timeout, counted in milliseconds; zero disables it
	wire        ms_tick   = (ms_pre == 16'(MS_CYCLES - 1));
	wire        timed_out = (state == S_RECV) && (act_timeout != 16'h0)
		&& (ms_cnt >= act_timeout);                                        // [R12]
	wire        retry     = timed_out && (retries != 16'h0);                  // [R22]
	wire        give_up   = timed_out && (retries == 16'h0);                  // [R22]

	// Start of a transfer taken from the pending send request
	wire        start_req = (state == S_IDLE) && port1_send_request;          // [R4]
	wire        bad_count = range_bad(tx_start, tx_count) || range_bad(rx_start, rx_count); // [R2]
	wire        go        = start_req && !bad_count;
	wire        reject    = start_req && bad_count;                           // [R21]

	// Buffer storage: software fills tx only when idle, engine fills rx
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_buf
			always_ff @(posedge clk_i) begin
				if (!rstn_i) begin
					tx_buf[g] <= 16'h0000;
					rx_buf[g] <= 16'h0000;
				end else begin
					if (wr_txbuf && win_idx == 10'(g))
						tx_buf[g] <= wdata_i;
					if (rx_word_v && (state == S_RECV) && rx_addr == 10'(g))
						rx_buf[g] <= rx_word;                               // [R16]
				end
			end
		end
	endgenerate

	// Operand and setting registers, frozen while a transfer runs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cfg                <= '0;
			port_format_code   <= FORMAT_RST;
			port_resend_count  <= RESEND_RST;
			port_reply_timeout <= TIMEOUT_RST;
			special_char_value <= SPECIAL_RST;
			tx_start           <= 16'h0000;
			tx_count           <= 16'h0000;
			rx_start           <= 16'h0000;
			rx_count           <= 16'h0000;
		end else if (wr_oper) begin
			case (addr_i)
				OFF_CONFIG:   cfg                <= sbt_cfg_type'(wdata_i[3:0]);
				OFF_FORMAT:   port_format_code   <= wdata_i;
				OFF_RESEND:   port_resend_count  <= wdata_i;
				OFF_TIMEOUT:  port_reply_timeout <= wdata_i;
				OFF_SPECIAL:  special_char_value <= wdata_i;
				OFF_TX_START: tx_start           <= wdata_i;
				OFF_TX_COUNT: tx_count           <= wdata_i;
				OFF_RX_START: rx_start           <= wdata_i;
				OFF_RX_COUNT: rx_count           <= wdata_i;
				default:      ;
			endcase
		end
	end

	// Settings in force follow the written ones only while enabled and idle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			act_cfg     <= '0;
			act_format  <= FORMAT_RST;
			act_resend  <= RESEND_RST;
			act_timeout <= TIMEOUT_RST;
		end else if (cfg.proto_en && !busy) begin                          // [R13]
			act_cfg     <= cfg;
			act_format  <= port_format_code;
			act_resend  <= port_resend_count;
			act_timeout <= port_reply_timeout;
		end
	end

	// Status flags; a hardware set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			port1_send_request   <= 1'b0;
			port1_rx_done        <= 1'b0;
			port1_rx_error       <= 1'b0;
			operation_error_flag <= 1'b0;
			special_seen         <= 1'b0;
			error_code_word      <= 16'h0000;
		end else begin
			// Software can only set the request; the engine clears it
			port1_send_request <= (wr_ctrl && wdata_i[CTRL_SEND])
				|| (port1_send_request && !send_end && !reject);           // [R14] [R15]
			port1_rx_done <= (rx_last && state == S_RECV)
				|| (port1_rx_done && !clr_bits[ST_RX_DONE]);               // [R17]
			port1_rx_error <= ((give_up || rx_frame) && state == S_RECV)
				|| (port1_rx_error && !clr_bits[ST_RX_ERR]);               // [R20]
			operation_error_flag <= reject
				|| (operation_error_flag && !clr_bits[ST_OP_ERR]);         // [R21]
			special_seen <= (rx_special && state == S_RECV)
				|| (special_seen && !clr_bits[ST_SPECIAL]);
			if (reject)
				error_code_word <= ERR_COUNT_RANGE;                         // [R21]
			else if (give_up)
				error_code_word <= ERR_RX_TIMEOUT;                          // [R20]
			else if (rx_frame && state == S_RECV)
				error_code_word <= ERR_RX_FRAME;                            // [R20]
		end
	end

	// Transfer control: one block at a time, send then receive
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state            <= S_IDLE;
			tx_pos           <= 10'h000;
			rx_pos           <= 10'h000;
			retries          <= 16'h0000;
			port1_rx_waiting <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (go) begin                                           // [R1] [R4]
						state   <= S_SEND;
						tx_pos  <= 10'h000;
						rx_pos  <= 10'h000;
						retries <= act_resend;                              // [R11]
					end
				end
				S_SEND: begin
					if (tx_load)
						tx_pos <= tx_pos + 10'h1;
					else if (send_end) begin                                // [R3]
						state            <= (rx_total == 10'h0) ? S_IDLE : S_RECV;
						port1_rx_waiting <= (rx_total != 10'h0);           // [R19]
						rx_pos           <= 10'h000;
					end
				end
				S_RECV: begin
					if (rx_last || rx_frame || give_up) begin               // [R19] [R20]
						state            <= S_IDLE;
						port1_rx_waiting <= 1'b0;
					end else if (retry) begin                               // [R22]
						state            <= S_SEND;
						retries          <= retries - 16'h1;
						tx_pos           <= 10'h000;
						port1_rx_waiting <= 1'b0;
					end else if (rx_byte_v)
						rx_pos <= rx_pos + 10'h1;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Low byte hold and timeout timer; a received byte restarts the wait
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_low <= 8'h00;
			ms_pre <= 16'h0000;
			ms_cnt <= 16'h0000;
		end else begin
			if (rx_byte_v && !rx_pos[0])
				rx_low <= rx_byte;                                          // [R7]
			if (state != S_RECV || rx_byte_v) begin
				ms_pre <= 16'h0000;
				ms_cnt <= 16'h0000;
			end else begin
				ms_pre <= ms_tick ? 16'h0000 : ms_pre + 16'h1;
				if (ms_tick)
					ms_cnt <= ms_cnt + 16'h1;
			end
		end
	end

	// Transmitter: start bit, data LSB first, one stop bit, no parity
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_sh   <= 10'h3FF;
			tx_left <= 4'h0;
			tx_baud <= 16'h0000;
		end else if (tx_load) begin
			// Stop bit placed directly above the data bits
			tx_sh   <= (data_bits == BITS_7) ? {2'b11, tx_data[6:0], 1'b0}
				: {1'b1, tx_data, 1'b0};
			tx_left <= data_bits + 4'h2;
			tx_baud <= 16'(BAUD_DIV - 1);
		end else if (!tx_idle) begin
			if (tx_baud == 16'h0) begin
				tx_sh   <= {1'b1, tx_sh[9:1]};
				tx_left <= tx_left - 4'h1;
				tx_baud <= 16'(BAUD_DIV - 1);
			end else
				tx_baud <= tx_baud - 16'h1;
		end
	end

	// Receiver: sample mid-bit after a half-bit start check
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_run  <= 1'b0;
			rx_bitn <= 4'h0;
			rx_baud <= 16'h0000;
			rx_sh   <= 8'h00;
		end else if (state != S_RECV) begin
			rx_run <= 1'b0;
		end else if (!rx_run) begin
			if (!ser_rx_i) begin
				rx_run  <= 1'b1;
				rx_bitn <= 4'h0;
				rx_baud <= 16'(BAUD_DIV / 2);
			end
		end else if (rx_baud != 16'h0) begin
			rx_baud <= rx_baud - 16'h1;
		end else if (rx_bitn == 4'h0 && ser_rx_i) begin
			rx_run <= 1'b0;                                                 // Glitch, not a start bit
		end else if (rx_stop) begin
			rx_run <= 1'b0;
		end else begin
			if (rx_bitn != 4'h0)
				rx_sh <= {ser_rx_i, rx_sh[7:1]};
			rx_bitn <= rx_bitn + 4'h1;
			rx_baud <= 16'(BAUD_DIV - 1);
		end
	end

	// Read data multiplexer
	wire [15:0] reg_rd =
		(addr_i == OFF_STATUS)   ? status_w :
		(addr_i == OFF_CONFIG)   ? {12'h0, cfg} :
		(addr_i == OFF_FORMAT)   ? port_format_code :
		(addr_i == OFF_RESEND)   ? port_resend_count :
		(addr_i == OFF_TIMEOUT)  ? port_reply_timeout :
		(addr_i == OFF_SPECIAL)  ? special_char_value :
		(addr_i == OFF_ERRCODE)  ? error_code_word :
		(addr_i == OFF_TX_START) ? tx_start :
		(addr_i == OFF_TX_COUNT) ? tx_count :
		(addr_i == OFF_RX_START) ? rx_start :
		(addr_i == OFF_RX_COUNT) ? rx_count : 16'h0000;
	wire [15:0] rd_mux =
		reg_hit ? reg_rd :
		(addr_i[11:10] == WIN_TX_BUF && win_ok) ? tx_buf[IDX_W'(win_idx)] :
		(addr_i[11:10] == WIN_RX_BUF && win_ok) ? rx_buf[IDX_W'(win_idx)] : 16'h0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			rdata_o <= 16'h0000;
		else
			rdata_o <= rd_i ? rd_mux : 16'h0000;
	end

	// Pin outputs; line driver only on the non RS-232 interfaces
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			special_char_interrupt_o <= 1'b0;
			driver_en_o              <= 1'b0;
		end else begin
			special_char_interrupt_o <= rx_special && (state == S_RECV);   // [R18]
			driver_en_o <= (act_cfg.iface != IFACE_RS232) && !tx_idle;     // [R9]
		end
	end
	assign ser_tx_o                = tx_sh[0];
	assign port_interface_select_o = act_cfg.iface;                          // [R9]

endmodule : sbt_engine

// File: verilog/sbt_pkg.sv
// Package: constants, register map and types for the serial block transfer engine
package sbt_pkg;

	// Register word offsets on the plain register port
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_STATUS   = 12'h001;
	localparam logic [11:0] OFF_CONFIG   = 12'h002;
	localparam logic [11:0] OFF_FORMAT   = 12'h003;
	localparam logic [11:0] OFF_RESEND   = 12'h004;
	localparam logic [11:0] OFF_TIMEOUT  = 12'h005;
	localparam logic [11:0] OFF_SPECIAL  = 12'h006;
	localparam logic [11:0] OFF_ERRCODE  = 12'h007;
	localparam logic [11:0] OFF_TX_START = 12'h008;
	localparam logic [11:0] OFF_TX_COUNT = 12'h009;
	localparam logic [11:0] OFF_RX_START = 12'h00A;
	localparam logic [11:0] OFF_RX_COUNT = 12'h00B;
	// Buffer windows, selected by address bits 11:10
	localparam logic [1:0]  WIN_TX_BUF   = 2'h1;
	localparam logic [1:0]  WIN_RX_BUF   = 2'h2;

	// Status bit positions
	localparam int ST_RX_DONE  = 0;
	localparam int ST_RX_WAIT  = 1;
	localparam int ST_RX_ERR   = 2;
	localparam int ST_OP_ERR   = 3;
	localparam int ST_SPECIAL  = 4;
	localparam int ST_BUSY     = 5;
	localparam int ST_SEND_REQ = 6;
	// Control bit: send request
	localparam int CTRL_SEND   = 0;

	// Reset values
	localparam logic [15:0] FORMAT_RST  = 16'h0020;
	localparam logic [15:0] RESEND_RST  = 16'h0000;
	localparam logic [15:0] TIMEOUT_RST = 16'h0BB8;
	localparam logic [15:0] SPECIAL_RST = 16'h0000;

	// Encodings
	localparam logic [15:0] FMT_9600_7N1   = 16'h0020;
	localparam logic [1:0]  IFACE_RS232    = 2'h0;
	localparam logic [15:0] ERR_COUNT_RANGE = 16'h200B;
	localparam logic [15:0] ERR_RX_TIMEOUT = 16'h0001;
	localparam logic [15:0] ERR_RX_FRAME   = 16'h0002;
	localparam logic [3:0]  BITS_7         = 4'h7;
	localparam logic [3:0]  BITS_8         = 4'h8;

	// Timing
	localparam int CLK_HZ   = 50_000_000;
	localparam int BAUD_HZ  = 9600;
	localparam int MS_PER_S = 1000;
	localparam int MAX_WORDS = 500;

	// Configuration word layout
	typedef struct packed {
		logic [1:0] iface;     // Physical interface select
		logic       proto_en;  // Protocol enable
		logic       byte_mode; // Set: 8-bit packing
	} sbt_cfg_type;

	// Engine states, Gray along idle, send, receive
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SEND = 2'b01,
		S_RECV = 2'b11
	} sbt_state_type;

endpackage : sbt_pkg
